// ===== hw/spll_pkg.sv
// constants and types shared by the system pll configuration and lock blocks
package spll_pkg;
  // -----------------------------------------------------------------
  // frequency word layout
  // -----------------------------------------------------------------
  localparam int FREQ_M_W = 48; // numerator width
  localparam int FREQ_N_W = 16; // denominator width

  // -----------------------------------------------------------------
  // pll control fields
  // -----------------------------------------------------------------
  localparam int FBDIV_W = 10; // feedback divider width
  localparam logic [9:0] FBDIV_MIN = 10'h06C; // least legal divider
  localparam logic [9:0] FBDIV_MAX = 10'h22C; // largest legal divider
  localparam logic [9:0] FBDIV_RST = 10'h1F4; // value before any load
  localparam logic DOUBLER_RST = 1'b0; // crystal used directly after reset

  // -----------------------------------------------------------------
  // lock detection
  // -----------------------------------------------------------------
  localparam int VCTRL_W = 12; // control voltage sample width
  localparam logic [11:0] VCTRL_MID = 12'h800; // centre of the window
  localparam logic [11:0] WIN_BASE = 12'h0C0; // fixed part of half window
  localparam int CLK_PERIOD_NS = 40; // sys_clk_i period
  localparam int LOCK_QUAL_NS = 10000; // in-window time before lock
  localparam int LOCK_QUAL_CYC = (LOCK_QUAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // -----------------------------------------------------------------
  // reset load sequence
  // -----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_START,
    ST_EE_WAIT,
    ST_FW_WAIT,
    ST_RUN
  } spll_load_e;
endpackage

// ===== hw/spll_lock_det.sv
// lock detector with limits derived from the active pll configuration
`timescale 1ns/100ps
module spll_lock_det
  import spll_pkg::*;
#(
  parameter int QUAL_CYC = LOCK_QUAL_CYC
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // configuration and control
  input wire logic restart_i,
  input wire logic doubler_i,
  input wire logic [FBDIV_W-1:0] fbdiv_i,
  input wire logic [VCTRL_W-1:0] vctrl_i,
  // status
  output logic locked_o
);
  // -----------------------------------------------------------------
  // limits
  // -----------------------------------------------------------------
  // half window grows with loop gain, wider with the doubler in use
  function automatic logic [VCTRL_W-1:0] half_win(input logic dbl,
                                                  input logic [FBDIV_W-1:0] fb);
    logic [VCTRL_W-1:0] ext;
    ext = {{(VCTRL_W-FBDIV_W){1'b0}}, fb};
    half_win = dbl ? WIN_BASE + (ext >> 2) : WIN_BASE + (ext >> 3);
  endfunction

  logic [VCTRL_W-1:0] half_w; // current half window
  logic [VCTRL_W-1:0] lim_lo; // lower limit
  logic [VCTRL_W-1:0] lim_hi; // upper limit
  logic in_win; // sample is inside the limits
  assign half_w = half_win(doubler_i, fbdiv_i);
  assign lim_lo = VCTRL_MID - half_w;
  assign lim_hi = VCTRL_MID + half_w;
  assign in_win = (vctrl_i >= lim_lo) && (vctrl_i <= lim_hi);

  // -----------------------------------------------------------------
  // qualification counter
  // -----------------------------------------------------------------
  localparam int CNT_W = $clog2(QUAL_CYC + 1);
  localparam logic [CNT_W-1:0] CNT_TOP = CNT_W'(QUAL_CYC);
  logic [CNT_W-1:0] cnt_reg; // consecutive in-window cycles
  logic [CNT_W-1:0] cnt_next;
  assign cnt_next = (restart_i || !in_win) ? '0 :
                    (cnt_reg == CNT_TOP) ? cnt_reg : cnt_reg + 1'b1;

  // count and lock flag
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end
  assign locked_o = (cnt_reg == CNT_TOP);

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  a_lock_drops_out: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (!in_win || restart_i) |=> !locked_o)
    else $error("lock held after window exit");
  a_lock_needs_qual: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    $rose(locked_o) |-> $past(in_win) && $past(in_win, 2) && $past(in_win, 3))
    else $error("lock rose without qualification");
endmodule

// ===== hw/spll_cfg.sv
// system pll configuration loader, host rewrite path and loss of lock alarm
`timescale 1ns/100ps
module spll_cfg
  import spll_pkg::*;
#(
  parameter int QUAL_CYC = LOCK_QUAL_CYC
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // one-time-programmable memory source
  input wire logic otp_en_i,
  input wire logic otp_valid_i,
  input wire logic otp_doubler_i,
  input wire logic [FBDIV_W-1:0] otp_fbdiv_i,
  // serial eeprom source
  input wire logic ee_en_i,
  output logic ee_rd_req_o,
  input wire logic ee_done_i,
  input wire logic ee_valid_i,
  input wire logic ee_doubler_i,
  input wire logic [FBDIV_W-1:0] ee_fbdiv_i,
  // firmware update revision
  input wire logic fw_present_i,
  input wire logic fw_load_done_i,
  output logic fw_wait_o,
  // host rewrite over the serial port
  input wire logic host_wr_i,
  input wire logic host_doubler_i,
  input wire logic [FBDIV_W-1:0] host_fbdiv_i,
  output logic host_ack_o,
  output logic host_nak_o,
  // crystal frequency and resulting pll frequency
  input wire logic [FREQ_M_W-1:0] xtal_m_i,
  input wire logic [FREQ_N_W-1:0] xtal_n_i,
  output logic [FREQ_M_W-1:0] pll_m_o,
  output logic [FREQ_N_W-1:0] pll_n_o,
  // analog pll control and feedback
  output logic doubler_o,
  output logic [FBDIV_W-1:0] fbdiv_o,
  input wire logic [VCTRL_W-1:0] vctrl_i,
  // status
  output logic cfg_ready_o,
  output logic lock_status_o,
  output logic lol_o,
  output logic lol_sticky_o,
  input wire logic lol_clr_i,
  input wire logic gpio_lol_en_i,
  output logic gpio_lol_o
);
  // -----------------------------------------------------------------
  // shared helpers
  // -----------------------------------------------------------------
  // legal feedback divider window
  function automatic logic fb_legal(input logic [FBDIV_W-1:0] fb);
    fb_legal = (fb >= FBDIV_MIN) && (fb <= FBDIV_MAX);
  endfunction

  // -----------------------------------------------------------------
  // reset load sequence
  // -----------------------------------------------------------------
  spll_load_e st_reg; // loader state
  spll_load_e st_next;
  logic otp_use; // otp enabled, valid and legal
  logic ee_use; // eeprom read returned legal valid data
  logic fw_ok; // update revision present or just loaded
  logic running; // reset sequence complete
  assign otp_use = otp_en_i && otp_valid_i && fb_legal(otp_fbdiv_i);
  assign ee_use = ee_done_i && ee_valid_i && fb_legal(ee_fbdiv_i);
  assign fw_ok = fw_present_i || fw_load_done_i;
  assign running = (st_reg == ST_RUN);

  // next loader state
  always_comb begin
    st_next = st_reg;
    case (st_reg)
      ST_START: begin
        // otp wins when enabled, valid and legal, else try the eeprom if enabled
        if (otp_use) begin
          st_next = ST_FW_WAIT;
        end else if (ee_en_i) begin
          st_next = ST_EE_WAIT;
        end else begin
          st_next = ST_FW_WAIT;
        end
      end
      ST_EE_WAIT: begin
        if (ee_done_i) begin
          st_next = ST_FW_WAIT;
        end
      end
      ST_FW_WAIT: begin
        // sequence holds until the update revision is in place
        if (fw_ok) begin
          st_next = ST_RUN;
        end
      end
      ST_RUN: begin
        st_next = ST_RUN;
      end
      default: begin
        st_next = ST_START;
      end
    endcase
  end

  // loader state register
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_reg <= ST_START;
    end else begin
      st_reg <= st_next;
    end
  end

  assign ee_rd_req_o = (st_reg == ST_EE_WAIT);
  assign fw_wait_o = (st_reg == ST_FW_WAIT) && !fw_ok;
  assign cfg_ready_o = running;

  // -----------------------------------------------------------------
  // control fields
  // -----------------------------------------------------------------
  logic load_otp; // take otp fields
  logic load_ee; // take eeprom fields
  logic host_ok; // host write accepted
  logic host_bad; // host write refused
  logic cfg_load; // any field update this cycle
  assign load_otp = (st_reg == ST_START) && otp_use;
  assign load_ee = (st_reg == ST_EE_WAIT) && ee_use;
  assign host_ok = host_wr_i && running && fb_legal(host_fbdiv_i);
  assign host_bad = host_wr_i && !host_ok;
  assign cfg_load = load_otp || load_ee || host_ok;

  logic doubler_reg; // crystal doubler select
  logic doubler_next;
  logic [FBDIV_W-1:0] fbdiv_reg; // feedback divider
  logic [FBDIV_W-1:0] fbdiv_next;
  assign doubler_next = load_otp ? otp_doubler_i :
                        load_ee ? ee_doubler_i :
                        host_ok ? host_doubler_i : doubler_reg;
  assign fbdiv_next = load_otp ? otp_fbdiv_i :
                      load_ee ? ee_fbdiv_i :
                      host_ok ? host_fbdiv_i : fbdiv_reg;

  // field registers
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      doubler_reg <= DOUBLER_RST;
      fbdiv_reg <= FBDIV_RST;
    end else begin
      doubler_reg <= doubler_next;
      fbdiv_reg <= fbdiv_next;
    end
  end
  assign doubler_o = doubler_reg;
  assign fbdiv_o = fbdiv_reg;

  // host answer pulses, one cycle after the write
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      host_ack_o <= 1'b0;
      host_nak_o <= 1'b0;
    end else begin
      host_ack_o <= host_ok;
      host_nak_o <= host_bad;
    end
  end

  // -----------------------------------------------------------------
  // pll frequency as an exact fraction
  // -----------------------------------------------------------------
  // m scales by doubler and divider, n is the crystal's own
  localparam int PROD_W = FREQ_M_W + FBDIV_W + 1;
  logic [FBDIV_W:0] mult; // total multiplication factor
  logic [PROD_W-1:0] prod; // full width product
  assign mult = doubler_reg ? {fbdiv_reg, 1'b0} : {1'b0, fbdiv_reg};
  assign prod = PROD_W'(xtal_m_i) * PROD_W'(mult);

  // registered frequency words
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pll_m_o <= '0;
      pll_n_o <= '0;
    end else begin
      pll_m_o <= prod[FREQ_M_W-1:0];
      pll_n_o <= xtal_n_i;
    end
  end

  // -----------------------------------------------------------------
  // lock detection and loss of lock alarm
  // -----------------------------------------------------------------
  logic locked; // qualified lock
  logic locked_q; // lock one cycle ago
  spll_lock_det #(
    .QUAL_CYC(QUAL_CYC)
  ) u_lock (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .restart_i(cfg_load || !running),
    .doubler_i(doubler_reg),
    .fbdiv_i(fbdiv_reg),
    .vctrl_i(vctrl_i),
    .locked_o(locked)
  );

  logic lol_set; // lock lost while running
  logic lol_sticky_next;
  assign lol_set = running && locked_q && !locked;
  assign lol_sticky_next = lol_set || (lol_sticky_o && !lol_clr_i); // set wins

  // previous lock and sticky alarm
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      locked_q <= 1'b0;
      lol_sticky_o <= 1'b0;
    end else begin
      locked_q <= locked;
      lol_sticky_o <= lol_sticky_next;
    end
  end

  assign lock_status_o = locked;
  assign lol_o = running && !locked;
  assign gpio_lol_o = gpio_lol_en_i && lol_o;

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  a_host_before_run: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (host_wr_i && !running) |=> host_nak_o && !host_ack_o)
    else $error("host write taken before reset sequence ended");
  a_fbdiv_range: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    $changed(fbdiv_reg) |-> fbdiv_reg >= FBDIV_MIN && fbdiv_reg <= FBDIV_MAX)
    else $error("feedback divider left legal range");
  a_host_apply: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    host_ok |=> host_ack_o && fbdiv_reg == $past(host_fbdiv_i))
    else $error("accepted host write not applied");
  a_otp_load: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    load_otp |=> fbdiv_reg == $past(otp_fbdiv_i) && doubler_reg == $past(otp_doubler_i))
    else $error("otp fields not loaded");
  a_fw_gate: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (st_reg == ST_FW_WAIT && !fw_ok) |=> !running)
    else $error("run entered without update revision");
  a_lol_set_wins: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    lol_set |=> lol_sticky_o)
    else $error("loss of lock event lost");
  a_gpio_follow: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    host_ok |=> !lock_status_o && (gpio_lol_o == gpio_lol_en_i))
    else $error("rewrite left lock or gpio alarm stale");
  a_freq_m: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    $stable(xtal_m_i) && $stable(mult) |=>
      pll_m_o == FREQ_M_W'(PROD_W'($past(xtal_m_i)) * PROD_W'($past(mult))))
    else $error("pll numerator wrong");
  c_otp_boot: cover property (@(posedge sys_clk_i) disable iff (rst_i)
    load_otp ##[1:4] running);
  c_ee_boot: cover property (@(posedge sys_clk_i) disable iff (rst_i)
    load_ee ##[1:20] running);
  c_host_rewrite: cover property (@(posedge sys_clk_i) disable iff (rst_i)
    host_ok ##1 host_ack_o);
  c_lock_lost: cover property (@(posedge sys_clk_i) disable iff (rst_i)
    lol_set ##[1:10] lol_clr_i);
endmodule

// ===== bench/spll_ee_model.sv
// configuration eeprom model answering read requests of the pll loader
`timescale 1ns/100ps
module spll_ee_model
  import spll_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // stored contents and read time
  input wire logic [7:0] delay_i,
  input wire logic valid_i,
  input wire logic doubler_i,
  input wire logic [FBDIV_W-1:0] fbdiv_i,
  // read handshake towards the loader
  input wire logic rd_req_i,
  output logic done_o,
  output logic valid_o,
  output logic doubler_o,
  output logic [FBDIV_W-1:0] fbdiv_o
);
  logic [7:0] cnt_reg; // cycles spent on the current read
  logic show_reg; // contents shown only in the done cycle

  // count the serial read time, then pulse done once
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_reg <= 8'h00;
      show_reg <= 1'b0;
    end else if (rd_req_i && !show_reg && cnt_reg == delay_i) begin
      cnt_reg <= 8'h00;
      show_reg <= 1'b1;
    end else if (rd_req_i && !show_reg) begin
      cnt_reg <= cnt_reg + 8'h01;
    end else begin
      show_reg <= 1'b0;
    end
  end

  // outside the done cycle the lines carry the inverse, never the real data
  assign done_o = show_reg;
  assign valid_o = show_reg ? valid_i : ~valid_i;
  assign doubler_o = show_reg ? doubler_i : ~doubler_i;
  assign fbdiv_o = show_reg ? fbdiv_i : ~fbdiv_i;
endmodule

// ===== bench/spll_cfg_bench.sv
// self-checking bench for the system pll loader, host path and lock alarm
`timescale 1ns/100ps
module spll_cfg_bench;
  import spll_pkg::*;
  // -----------------------------------------------------------------
  // stimulus and observed signals
  // -----------------------------------------------------------------
  localparam int QC = 4; // short lock qualification
  localparam logic [47:0] XM = 48'h0000_017D_7840; // 25 MHz crystal
  localparam logic [11:0] PROBE = 12'h0904; // inside 0x105, outside 0x103
  logic sys_clk_i = 1'b0, rst_i = 1'b1;
  logic otp_en = 1'b0, otp_vld = 1'b0, otp_dbl = 1'b0, ee_en = 1'b0;
  logic fw_present = 1'b0, fw_done = 1'b0, lol_clr = 1'b0, gpio_en = 1'b0;
  logic host_wr = 1'b0, host_dbl = 1'b0, host_ok = 1'b0;
  logic [9:0] otp_fb = 10'h000, host_fb = 10'h000, st_fb = 10'h000;
  logic [11:0] vctrl = 12'h000;
  logic [7:0] ee_delay = 8'h0A;
  logic ee_vsrc = 1'b1; // eeprom contents marked valid
  logic [1:0] exp_q = 2'b00; // host write seen at the last edge, and outcome
  logic ee_req, ee_done, ee_vld, ee_dbl, fw_wait, ack, nak, dbl_o, ready;
  logic lock, lol, sticky, gpio;
  logic [9:0] ee_fb, fb_o;
  logic [47:0] pll_m;
  logic [15:0] pll_n;
  int bad_count = 0, check_count = 0, cyc = 0;

  // -----------------------------------------------------------------
  // design, eeprom model and clock
  // -----------------------------------------------------------------
  spll_cfg #(.QUAL_CYC(QC)) u_spll_cfg (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .otp_en_i(otp_en), .otp_valid_i(otp_vld), .otp_doubler_i(otp_dbl),
    .otp_fbdiv_i(otp_fb), .ee_en_i(ee_en), .ee_rd_req_o(ee_req), .ee_done_i(ee_done),
    .ee_valid_i(ee_vld), .ee_doubler_i(ee_dbl), .ee_fbdiv_i(ee_fb),
    .fw_present_i(fw_present), .fw_load_done_i(fw_done), .fw_wait_o(fw_wait),
    .host_wr_i(host_wr), .host_doubler_i(host_dbl), .host_fbdiv_i(host_fb),
    .host_ack_o(ack), .host_nak_o(nak), .xtal_m_i(XM), .xtal_n_i(16'h0001),
    .pll_m_o(pll_m), .pll_n_o(pll_n), .doubler_o(dbl_o), .fbdiv_o(fb_o),
    .vctrl_i(vctrl), .cfg_ready_o(ready), .lock_status_o(lock), .lol_o(lol),
    .lol_sticky_o(sticky), .lol_clr_i(lol_clr), .gpio_lol_en_i(gpio_en),
    .gpio_lol_o(gpio));
  spll_ee_model u_spll_ee_model (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .delay_i(ee_delay), .valid_i(ee_vsrc), .doubler_i(1'b0), .fbdiv_i(st_fb),
    .rd_req_i(ee_req), .done_o(ee_done), .valid_o(ee_vld), .doubler_o(ee_dbl),
    .fbdiv_o(ee_fb));
  always #20 sys_clk_i = ~sys_clk_i;

  // -----------------------------------------------------------------
  // checking helpers
  // -----------------------------------------------------------------
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // active settings and the m/n word they give
  task automatic chk_cfg(input logic d, input logic [9:0] f);
    logic [63:0] m;
    m = {16'h0000, XM} * (d ? 64'h2 : 64'h1) * {54'h0, f};
    chk(fb_o, f);
    chk(dbl_o, d);
    chk(pll_m, {16'h0000, m[47:0]});
    chk(pll_n, 16'h0001);
  endtask

  // host strobe, called at an edge; caller lowers the strobe afterwards
  task automatic put(input logic d, input logic [9:0] f, input logic ok);
    host_wr <= 1'b1;
    host_dbl <= d;
    host_fb <= f;
    host_ok <= ok;
    @(posedge sys_clk_i);
  endtask

  // answer to every strobe is a one-cycle ack or nak, silence otherwise
  always @(posedge sys_clk_i) exp_q <= {host_wr, host_ok};
  always @(negedge sys_clk_i) chk({ack, nak}, exp_q[1] ? {exp_q[0], ~exp_q[0]} : 2'b00);

  task automatic boot();
    rst_i <= 1'b1;
    repeat (20) @(posedge sys_clk_i);
    rst_i <= 1'b0;
  endtask

  task automatic wait_ready();
    @(negedge sys_clk_i);
    for (int i = 0; i < 100 && ready !== 1'b1; i++) @(negedge sys_clk_i);
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // hang guard
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      end_sim();
    end
  end

  // -----------------------------------------------------------------
  // test sequence
  // -----------------------------------------------------------------
  initial begin
    // otp enabled and valid at the lowest divider
    otp_en <= 1'b1; otp_vld <= 1'b1; otp_dbl <= 1'b1; otp_fb <= 10'h06C;
    fw_present <= 1'b1;
    boot();
    wait_ready();
    @(negedge sys_clk_i);
    chk(ee_req, 1'b0);
    chk_cfg(1'b1, 10'h06C);
    $display("test otp load done");
    // otp out of range, eeprom at the top divider, update revision missing
    @(posedge sys_clk_i);
    otp_fb <= 10'h06B; ee_en <= 1'b1; st_fb <= 10'h22C; fw_present <= 1'b0;
    boot();
    repeat (3) @(posedge sys_clk_i);
    put(1'b0, 10'h21C, 1'b0);
    host_wr <= 1'b0;
    @(negedge sys_clk_i);
    chk({ee_req, ready}, 2'b10);
    for (int i = 0; i < 40 && ee_req !== 1'b0; i++) @(negedge sys_clk_i);
    repeat (3) @(negedge sys_clk_i);
    chk({fw_wait, ready, fb_o}, {2'b10, 10'h22C});
    @(posedge sys_clk_i);
    fw_done <= 1'b1;
    @(posedge sys_clk_i);
    fw_done <= 1'b0;
    wait_ready();
    @(negedge sys_clk_i);
    chk({fw_wait, ready}, 2'b01);
    chk_cfg(1'b0, 10'h22C);
    $display("test eeprom load done");
    // lock window widened by the large divider accepts the probe voltage
    @(posedge sys_clk_i);
    vctrl <= VCTRL_MID;
    gpio_en <= 1'b1;
    repeat (QC + 3) @(posedge sys_clk_i);
    vctrl <= PROBE;
    repeat (3) @(negedge sys_clk_i);
    chk({lock, lol, sticky, gpio}, 4'b1000);
    // back-to-back host writes in the tuning range and refused neighbours
    @(posedge sys_clk_i);
    put(1'b0, 10'h21C, 1'b1);
    put(1'b1, 10'h22D, 1'b0);
    put(1'b1, 10'h06B, 1'b0);
    host_wr <= 1'b0;
    repeat (2) @(negedge sys_clk_i);
    chk_cfg(1'b0, 10'h21C);
    chk({lock, lol, sticky, gpio}, 4'b0111);
    @(posedge sys_clk_i);
    put(1'b1, 10'h10E, 1'b1);
    host_wr <= 1'b0;
    lol_clr <= 1'b1;
    @(posedge sys_clk_i);
    lol_clr <= 1'b0;
    repeat (QC + 3) @(negedge sys_clk_i);
    chk_cfg(1'b1, 10'h10E);
    chk({lock, sticky}, 2'b00);
    $display("test host rewrite done");
    // narrower doubled window: probe out, middle in, then lose lock
    @(posedge sys_clk_i);
    vctrl <= VCTRL_MID;
    repeat (QC + 3) @(negedge sys_clk_i);
    chk({lock, lol}, 2'b10);
    @(posedge sys_clk_i);
    gpio_en <= 1'b0;
    vctrl <= PROBE;
    @(posedge sys_clk_i);
    // clear lands on the same edge as the loss of lock event
    lol_clr <= 1'b1;
    @(posedge sys_clk_i);
    lol_clr <= 1'b0;
    @(negedge sys_clk_i);
    chk({lock, lol, sticky, gpio}, 4'b0110);
    @(posedge sys_clk_i);
    gpio_en <= 1'b1;
    @(negedge sys_clk_i);
    chk(gpio, 1'b1);
    $display("test lock alarm done");
    // otp not valid and eeprom read marked invalid: reset fields stay
    @(posedge sys_clk_i);
    otp_vld <= 1'b0; ee_vsrc <= 1'b0; fw_present <= 1'b1;
    boot();
    wait_ready();
    @(negedge sys_clk_i);
    chk({ee_req, ready}, 2'b01);
    chk_cfg(DOUBLER_RST, FBDIV_RST);
    $display("test refused load done");
    end_sim();
  end
endmodule
